/* cfs_asserts.sv */
// Concurrent checks on the fault supervisor ports.
// Assumes it is bound into every cfs_supervisor instance.
`timescale 1ns/1ps
module cfs_asserts #(
  parameter int unsigned DELAY_CYCLES = 20
) (
  input wire logic                        clk,              // Switching clock
  input wire logic                        srst,             // Synchronous reset, high
  input wire logic                        main_supply_por,  // Main-supply power reset
  input wire logic                        group_enable_pin, // Group enable
  input wire logic                        unit_off,         // Unit fully shut down
  input wire logic                        hv_boost_ocp,     // Boost over-current
  input wire logic                        hv_boost_fb_low,  // Boost feedback low
  input wire logic                        hv_boost_ss_done, // Boost soft-start ended
  input wire logic                        inv_ocp,          // Inverting over-current
  input wire logic                        led_ocp,          // LED over-current
  input wire logic                        led_ovp,          // LED overvoltage
  input wire logic                        hv_boost_sw_off,  // Boost switches off
  input wire logic                        inv_sw_off,       // Inverting switch off
  input wire logic                        led_sw_off,       // LED switches off
  input wire logic                        led_latched_off,  // LED latch
  input wire logic                        unit_shutdown,    // Unit shutdown latch
  input wire logic [cfs_pkg::CTRL0_W-1:0] ctrl0_q           // Control register zero
);
  import cfs_pkg::*;
  logic [31:0] run_cnt_reg;
  // Length of the current unbroken fault run at the inputs
  always_ff @(posedge clk) begin
    if (srst || main_supply_por || !group_enable_pin)
      run_cnt_reg <= '0;
    else if (!(hv_boost_ocp || inv_ocp || led_ocp || (hv_boost_fb_low && hv_boost_ss_done)))
      run_cnt_reg <= '0;
    else
      run_cnt_reg <= run_cnt_reg + 32'h0000_0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_ss_settled; hv_boost_ss_done [*4]; endsequence
  sequence s_ovp_gone; (!led_ovp) [*4]; endsequence
  sequence s_quiet; (!group_enable_pin && unit_off) [*3]; endsequence
  chk_boost_ocp_off: assert property ($rose(hv_boost_ocp) |-> ##[3:4] hv_boost_sw_off)
    else $error("boost switches stay on after over-current");
  chk_timer_fires: assert property (run_cnt_reg == DELAY_CYCLES + 6 |-> unit_shutdown)
    else $error("no shutdown after a full fault run");
  chk_boost_uv_off: assert property (s_ss_settled ##0 $rose(hv_boost_fb_low) |-> ##[3:4] hv_boost_sw_off)
    else $error("boost switches stay on after low feedback");
  chk_inv_ocp_off: assert property ($rose(inv_ocp) |-> ##[3:4] inv_sw_off)
    else $error("inverting switch stays on after over-current");
  chk_led_ocp_off: assert property ($rose(led_ocp) |-> ##[3:4] led_sw_off)
    else $error("led switches stay on after over-current");
  chk_led_ovp_latch: assert property ($rose(led_ovp) && group_enable_pin |-> ##[3:4] led_latched_off)
    else $error("led overvoltage not latched");
  chk_shutdown_hold: assert property (unit_shutdown && group_enable_pin && !main_supply_por |=> unit_shutdown)
    else $error("shutdown latch dropped without a clear");
  chk_enable_clear: assert property (s_ovp_gone ##0 !group_enable_pin |=> !led_latched_off)
    else $error("led latch kept with group enable low");
  chk_ctrl_default: assert property (s_quiet |=> ctrl0_q == CTRL0_RESET)
    else $error("control register not back to default");
  chk_timer_restart: assert property ($rose(unit_shutdown) |-> $past(run_cnt_reg) >= DELAY_CYCLES)
    else $error("shutdown before a full unbroken fault run");
endmodule
bind cfs_supervisor cfs_asserts #(.DELAY_CYCLES(DELAY_CYCLES)) cfs_asserts_inst (.*);

/* cfs_pkg.sv */
// Constants for the converter fault supervisor.
// Assumes a single 25 MHz switching clock.
package cfs_pkg;
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned DELAY_MS        = 100;
  localparam int unsigned DELAY_CYCLES    = (CLK_HZ / 1000) * DELAY_MS;
  localparam int unsigned CLR_FIELD_W     = 5;
  localparam logic [4:0]  CLR_FIELD_VALUE = 5'h00;
  localparam logic [7:0]  CTRL0_RESET     = 8'h00;
  localparam int unsigned CTRL0_W         = 8;
endpackage

/* cfs_supervisor.sv */
// Fault supervision logic for the high-voltage boost, inverting and LED driver channels.
// Assumes comparator fault inputs are asynchronous levels and the clock is the switching clock.
`timescale 1ns/1ps

// Notes on behaviour
// - A boost low-side over-current turns off both switches for the cycle and shuts the unit down if it lasts 100 ms.
// - After soft-start a low boost feedback turns off both boost switches and shuts the unit down after 100 ms.
// - An inverting high-side over-current turns off that switch for the cycle and shuts the unit down if it lasts 100 ms.
// - An LED low-side over-current turns off both switches for the cycle and shuts the unit down if it lasts 100 ms.
// - An LED output overvoltage latches off the LED channel until main-supply reset with a zero write to field 4:0.
// - Latched shutdowns clear only on main-supply power reset or group enable low.
// - Control register zero returns to its default once group enable is low and the unit is fully shut down.
module cfs_supervisor #(
  parameter int unsigned DELAY_CYCLES = cfs_pkg::DELAY_CYCLES
) (
  input  wire logic                        clk,               // 25 MHz switching clock
  input  wire logic                        srst,              // Synchronous reset, high
  input  wire logic                        main_supply_por,   // Main-supply power reset pulse/level
  input  wire logic                        group_enable_pin,  // Group enable, low clears latches
  input  wire logic                        hv_boost_ocp,      // Boost low-side current above limit
  input  wire logic                        hv_boost_fb_low,   // Boost feedback below threshold
  input  wire logic                        hv_boost_ss_done,  // Boost soft-start has ended
  input  wire logic                        inv_ocp,           // Inverting high-side current above limit
  input  wire logic                        led_ocp,           // LED low-side current above limit
  input  wire logic                        led_ovp,           // LED output rail overvoltage
  input  wire logic                        ctrl0_wr,          // Write strobe for control register zero
  input  wire logic [cfs_pkg::CTRL0_W-1:0] ctrl0_wdata,       // Write data for control register zero
  input  wire logic                        unit_off,          // Converter unit fully shut down
  output logic                             hv_boost_sw_off,   // Boost both switches off
  output logic                             inv_sw_off,        // Inverting high-side switch off
  output logic                             led_sw_off,        // LED both switches off
  output logic                             led_latched_off,   // LED channel latched off
  output logic                             unit_shutdown,     // Latched converter unit shutdown
  output logic [cfs_pkg::CTRL0_W-1:0]      ctrl0_q            // Control register zero
);
  import cfs_pkg::*;

  // Refuse parameter values that the counters and the clear-field compare cannot serve
  if (DELAY_CYCLES < 1) begin : g_bad_delay
    $error("DELAY_CYCLES must be at least one");
  end
  if (CLR_FIELD_W < 1 || CLR_FIELD_W > CTRL0_W) begin : g_bad_field
    $error("clear field must fit inside control register zero");
  end

  localparam int unsigned   NF            = 6;
  localparam int unsigned   CW            = $clog2(DELAY_CYCLES + 1);
  localparam logic [CW-1:0] CMAX          = CW'(DELAY_CYCLES);
  localparam int unsigned   IDX_BOOST_OCP = 0;
  localparam int unsigned   IDX_BOOST_FB  = 1;
  localparam int unsigned   IDX_INV_OCP   = 2;
  localparam int unsigned   IDX_LED_OCP   = 3;
  localparam int unsigned   IDX_LED_OVP   = 4;
  localparam int unsigned   IDX_BOOST_SS  = 5;

  logic [NF-1:0] fault_raw;
  logic [NF-1:0] meta_reg;
  logic [NF-1:0] sync_reg;
  logic          boost_ocp_s;
  logic          boost_fb_low_s;
  logic          inv_ocp_s;
  logic          led_ocp_s;
  logic          led_ovp_s;
  logic          boost_ss_done_s;
  logic          clear_all;
  logic          boost_uv;
  logic [2:0]    timer_fault;
  logic [2:0]    expired;
  logic          clr_write_zero;
  logic          led_latch_clear;
  logic          ctrl0_default_now;
  logic          led_clr_arm_reg;
  logic          main_por_seen_reg;

  // Timer grouping: boost over-current and undervoltage share one timer, either keeps it counting
  function automatic logic [2:0] timer_faults(
    input logic boost_ocp_in,
    input logic boost_uv_in,
    input logic inv_ocp_in,
    input logic led_ocp_in
  );
    logic [2:0] f;
    f    = 3'b000;
    f[0] = boost_ocp_in | boost_uv_in;
    f[1] = inv_ocp_in;
    f[2] = led_ocp_in;
    return f;
  endfunction

  // True when the written value clears the LED overvoltage field
  function automatic logic clear_field_zero(input logic [CTRL0_W-1:0] wdata);
    return wdata[CLR_FIELD_W-1:0] == CLR_FIELD_VALUE;
  endfunction

  assign fault_raw = {hv_boost_ss_done, led_ovp, led_ocp, inv_ocp, hv_boost_fb_low, hv_boost_ocp};

  // Two-flop synchronisers on all comparator inputs; only the second rank is read
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= fault_raw;
      sync_reg <= meta_reg;
    end
  end

  // Fault indications by name
  assign boost_ocp_s     = sync_reg[IDX_BOOST_OCP];
  assign boost_fb_low_s  = sync_reg[IDX_BOOST_FB];
  assign inv_ocp_s       = sync_reg[IDX_INV_OCP];
  assign led_ocp_s       = sync_reg[IDX_LED_OCP];
  assign led_ovp_s       = sync_reg[IDX_LED_OVP];
  assign boost_ss_done_s = sync_reg[IDX_BOOST_SS];

  // Clears act on the pins directly, so a clear is never delayed behind the synchronisers
  assign clear_all         = main_supply_por | ~group_enable_pin;
  // Boost undervoltage only counts once soft-start has ended
  assign boost_uv          = boost_fb_low_s & boost_ss_done_s;
  assign timer_fault       = timer_faults(boost_ocp_s, boost_uv, inv_ocp_s, led_ocp_s);
  assign clr_write_zero    = ctrl0_wr & clear_field_zero(ctrl0_wdata);
  assign led_latch_clear   = ~group_enable_pin | led_clr_arm_reg;
  assign ctrl0_default_now = ~group_enable_pin & unit_off;

  // Boost: both switches off for the cycle, resumes when the indication drops
  always_ff @(posedge clk) begin
    if (srst) begin
      hv_boost_sw_off <= 1'b0;
    end else begin
      hv_boost_sw_off <= boost_ocp_s | boost_uv | unit_shutdown;
    end
  end

  // Inverting: only the high-side switch is turned off
  always_ff @(posedge clk) begin
    if (srst) begin
      inv_sw_off <= 1'b0;
    end else begin
      inv_sw_off <= inv_ocp_s | unit_shutdown;
    end
  end

  // LED: both switches off on over-current, and held off while overvoltage is latched
  always_ff @(posedge clk) begin
    if (srst) begin
      led_sw_off <= 1'b0;
    end else begin
      led_sw_off <= led_ocp_s | led_ovp_s | led_latched_off | unit_shutdown;
    end
  end

  // Delay timers: boost faults, inverting over-current, LED over-current
  // Each counter saturates at the delay so expiry stays high while the fault remains
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_tmr
      logic [CW-1:0] cnt_reg;
      always_ff @(posedge clk) begin
        if (srst || clear_all || !timer_fault[g]) begin
          cnt_reg <= '0;
        end else if (cnt_reg != CMAX) begin
          cnt_reg <= cnt_reg + CW'(1);
        end
      end
      assign expired[g] = (cnt_reg == CMAX);
    end
  endgenerate

  // Latched unit shutdown
  // Set wins over a clear in the same cycle so an expiry is never lost
  always_ff @(posedge clk) begin
    if (srst) begin
      unit_shutdown <= 1'b0;
    end else if (|expired) begin
      unit_shutdown <= 1'b1;
    end else if (clear_all) begin
      unit_shutdown <= 1'b0;
    end
  end

  // LED overvoltage latch: clears on group enable low, or main-supply reset plus zero write
  // Remembers a main-supply reset until the zero write uses it or the latch is already clear
  always_ff @(posedge clk) begin
    if (srst) begin
      main_por_seen_reg <= 1'b0;
    end else if (main_supply_por) begin
      main_por_seen_reg <= 1'b1;
    end else if (!led_latched_off || led_clr_arm_reg) begin
      main_por_seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      led_clr_arm_reg <= 1'b0;
    end else begin
      led_clr_arm_reg <= clr_write_zero && (main_por_seen_reg || main_supply_por);
    end
  end

  // Overvoltage still present beats a clear, so the channel cannot restart into the fault
  always_ff @(posedge clk) begin
    if (srst) begin
      led_latched_off <= 1'b0;
    end else if (led_ovp_s) begin
      led_latched_off <= 1'b1;
    end else if (led_latch_clear) begin
      led_latched_off <= 1'b0;
    end
  end

  // Control register zero storage
  // A write in the same cycle as the default condition is dropped, the default wins
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl0_q <= CTRL0_RESET;
    end else if (ctrl0_default_now) begin
      ctrl0_q <= CTRL0_RESET;
    end else if (ctrl0_wr) begin
      ctrl0_q <= ctrl0_wdata;
    end
  end
endmodule

/* cfs_supervisor_test.sv */
// Self-checking bench for the fault supervisor.
// Assumes a shortened shutdown delay of 20 cycles.
`timescale 1ns/1ps
module cfs_supervisor_test;
  import cfs_pkg::*;
  logic       clk, srst, por, en, b_ocp, fb_low, ss, i_ocp, l_ocp, ovp, wr, uoff;
  logic       b_off, i_off, l_off, l_lat, sd;
  logic [7:0] wd, q;
  int         fail_count = 0;
  int         samples_checked = 0;
  cfs_supervisor #(.DELAY_CYCLES(20)) cfs_supervisor_inst (.clk(clk), .srst(srst), .main_supply_por(por),
    .group_enable_pin(en), .hv_boost_ocp(b_ocp), .hv_boost_fb_low(fb_low), .hv_boost_ss_done(ss),
    .inv_ocp(i_ocp), .led_ocp(l_ocp), .led_ovp(ovp), .ctrl0_wr(wr), .ctrl0_wdata(wd), .unit_off(uoff),
    .hv_boost_sw_off(b_off), .inv_sw_off(i_off), .led_sw_off(l_off), .led_latched_off(l_lat),
    .unit_shutdown(sd), .ctrl0_q(q));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic results;
    $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic ocp_cut;
    for (int k = 0; k < 3; k++) begin
      {b_ocp, i_ocp, l_ocp} = 3'b100 >> k;
      step(6);
      check({b_off, i_off, l_off, sd}, {3'b100 >> k, 1'b0});
      {b_ocp, i_ocp, l_ocp} = 3'b000;
      step(6);
      check({b_off, i_off, l_off}, 8'h00);
    end
  endtask
  task automatic timer_run;
    b_ocp = 1;
    step(16);
    b_ocp = 0;
    step(1);
    b_ocp = 1;
    step(16);
    check(sd, 8'h00);
    step(10);
    check(sd, 8'h01);
    b_ocp = 0;
    step(8);
    check(sd, 8'h01);
    por = 1;
    step(1);
    por = 0;
    step(4);
    check(sd, 8'h00);
  endtask
  task automatic uv_clear;
    {ss, fb_low} = 2'b01;
    step(6);
    check({b_off, sd}, 8'h00);
    {ss, fb_low} = 2'b10;
    step(4);
    fb_low = 1;
    step(6);
    check(b_off, 8'h01);
    step(25);
    fb_low = 0;
    step(4);
    check(sd, 8'h01);
    en = 0;
    step(4);
    check(sd, 8'h00);
    en = 1;
    step(2);
  endtask
  task automatic led_trip;
    ovp = 1;
    step(5);
    check({l_lat, l_off, b_off}, 8'h06);
    ovp = 0;
    step(4);
    wr = 1;
    step(1);
    wr = 0;
    step(4);
    check(l_lat, 8'h01);
    por = 1;
    step(1);
    wr = 1;
    step(1);
    {por, wr} = 2'b00;
    step(4);
    check(l_lat, 8'h00);
    ovp = 1;
    step(5);
    check(l_lat, 8'h01);
    ovp = 0;
    step(4);
    en = 0;
    step(2);
    check(l_lat, 8'h00);
    en = 1;
    step(2);
  endtask
  task automatic ctrl_reset;
    wd = 8'ha5;
    wr = 1;
    step(1);
    wr = 0;
    step(2);
    check(q, 8'ha5);
    {en, uoff} = 2'b01;
    step(4);
    check(q, CTRL0_RESET);
    {en, uoff} = 2'b10;
    step(2);
  endtask
  initial begin
    {por, b_ocp, fb_low, i_ocp, l_ocp, ovp, wr, uoff, wd} = '0;
    {en, ss, srst} = 3'b111;
    step(12);
    srst = 0;
    ocp_cut();
    timer_run();
    uv_clear();
    led_trip();
    ctrl_reset();
    results();
  end
  initial begin
    #100000;
    fail_count++;
    results();
  end
endmodule
